// [rtl/dmmap_params.svh]
// Address map, field positions and reset values of the data memory map
`ifndef DMMAP_PARAMS_SVH
`define DMMAP_PARAMS_SVH

`define DMMAP_LOWER_TOP      8'h7F
`define DMMAP_BANK_LIMIT     8'h1F
`define DMMAP_BIT_BASE       8'h20
`define DMMAP_BIT_LIMIT      8'h2F
`define DMMAP_PTR_HI         8'h83
`define DMMAP_PTR_LO         8'h84
`define DMMAP_STATUS_ADDR    8'hD0
`define DMMAP_SFR_AUX        8'hA2
`define DMMAP_EXPANDED_TOP   16'h00FF
`define DMMAP_BANK_HI        4
`define DMMAP_BANK_LO        3
`define DMMAP_AUX_SEL        0
`define DMMAP_AUX_ZERO       2
`define DMMAP_AUX_FLAG       3
`define DMMAP_STATUS_RESET   8'h00
`define DMMAP_AUX_RESET      8'h00
`define DMMAP_PTR_RESET      16'h0000

`endif

// [rtl/dmmap_pkg.sv]
// Types shared by the data memory map
package dmmap_pkg;

	typedef enum logic [2:0]
	{
		DMMAP_MODE_DIRECT   = 3'b001,
		DMMAP_MODE_INDIRECT = 3'b010,
		DMMAP_MODE_EXT      = 3'b100
	} dmmap_mode_t;

endpackage : dmmap_pkg

// [rtl/dmmap_ram.sv]
// Single-port byte RAM, written on the clock, read straight from the cells
`timescale 1ns/10ps

module dmmap_ram #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk_in,
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [7:0]        wdata_in,
	output logic      [7:0]        rdata_out
);

	// Volatile cells: no reset, contents undefined until software writes
	logic [7:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge sys_clk_in)
	begin
		if (wr_en_in)
			mem[addr_in] <= wdata_in;
	end

	// Combinational read lets the caller register the answer together
	// with its own source select and still reply one cycle later
	assign rdata_out = mem[addr_in];

endmodule : dmmap_ram

// [rtl/dmmap_top.sv]
// Internal data memory decoder with bank select and dual data pointer
`timescale 1ns/10ps
`include "dmmap_params.svh"

// Summary of operation
// - Lower RAM 00h-7Fh answers both direct and indirect accesses.
// - Lowest 32 bytes form four banks of eight working registers.
// - Bank bits 00,01,10,11 select bases 00h,08h,10h,18h.
// - Bytes 20h-2Fh hold 128 bits at bit addresses 00h-7Fh.
// - Upper RAM 80h-FFh reachable only by indirect accesses.
// - Direct accesses at 80h-FFh go to the SPECIAL_FUNCTION_REGISTER space.
// - Expanded RAM answers external-data accesses 0000h-00FFh.
// - All RAM is volatile; contents undefined until software writes.
// - Two 16-bit pointers share SPECIAL_FUNCTION_REGISTER 83h and 84h; only the selected one appears there.
// - Increment of the aux control register toggles pointer select.
// - Aux bit 0 selects second pointer when set, first when clear.
// - Aux bit 2 always reads zero so increments spare the flag.
module dmmap_top
	import dmmap_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_in,
	input  wire logic        wr_in,
	input  dmmap_mode_t      mode_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        reg_op_in,
	input  wire logic [2:0]  reg_num_in,
	input  wire logic        bit_op_in,
	input  wire logic [6:0]  bit_addr_in,
	input  wire logic        bit_wdata_in,
	input  wire logic        ptr_inc_in,
	input  wire logic        aux_inc_in,
	input  wire logic        ext_ptr_in,
	output logic      [7:0]  rdata_out,
	output logic             rbit_out,
	output logic             ack_out,
	output logic             sfr_miss_out,
	output logic      [15:0] active_data_pointer_out,
	output logic             pointer_select_out,
	output logic      [1:0]  bank_out
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [7:0]  program_status_word_reg;
	logic [7:0]  aux_control_reg;
	logic [15:0] first_data_pointer_reg;
	logic [15:0] second_data_pointer_reg;
	logic        bank_select_low;
	logic        bank_select_high;
	logic        pointer_select;
	logic [15:0] active_data_pointer;
	logic [7:0]  bank_base;
	logic [7:0]  eff_addr;
	logic [15:0] ext_addr;
	logic        iram_sel;
	logic        exp_sel;
	logic        sfr_sel;
	logic        bit_sel;
	logic [7:0]  bit_byte;
	logic        ext_miss;

	assign bank_select_low  = program_status_word_reg[`DMMAP_BANK_LO];
	assign bank_select_high = program_status_word_reg[`DMMAP_BANK_HI];
	assign pointer_select   = aux_control_reg[`DMMAP_AUX_SEL];
	assign active_data_pointer = pointer_select ?
		second_data_pointer_reg : first_data_pointer_reg;

	// Bank base is the bank number times eight
	assign bank_base = {3'h0, bank_select_high, bank_select_low, 3'h0};

	// Bit address 00h-7Fh maps to bytes 20h-2Fh, eight bits per byte
	assign bit_byte = `DMMAP_BIT_BASE + {4'h0, bit_addr_in[6:3]};

	always_comb
	begin
		eff_addr = addr_in[7:0];
		if (reg_op_in)
			eff_addr = bank_base + {5'h00, reg_num_in};
		else if (bit_op_in)
			eff_addr = bit_byte;
	end

	assign ext_addr = ext_ptr_in ? active_data_pointer : addr_in;

	// Direct above 7Fh is SPECIAL_FUNCTION_REGISTER; indirect reaches the whole 256 bytes
	assign sfr_sel = req_in && mode_in == DMMAP_MODE_DIRECT &&
		!reg_op_in && !bit_op_in &&
		eff_addr > `DMMAP_LOWER_TOP;
	assign iram_sel = req_in && (mode_in == DMMAP_MODE_INDIRECT ||
		(mode_in == DMMAP_MODE_DIRECT && !sfr_sel));
	assign ext_miss = ext_addr > `DMMAP_EXPANDED_TOP;
	assign exp_sel  = req_in && mode_in == DMMAP_MODE_EXT && !ext_miss;
	assign bit_sel = bit_op_in && mode_in == DMMAP_MODE_DIRECT;

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	logic [7:0] iram_rdata;
	logic [7:0] exp_rdata;
	logic [7:0] iram_wdata;
	logic       iram_we;

	// Bit writes merge one bit into the byte given in wdata_in, not the RAM byte read;
	// the CPU supplies the byte in wdata_in from a preceding read.
	always_comb
	begin
		iram_wdata = wdata_in;
		if (bit_sel)
		begin
			iram_wdata = wdata_in;
			iram_wdata[bit_addr_in[2:0]] = bit_wdata_in;
		end
	end

	assign iram_we = iram_sel && wr_in;

	// Neither RAM is reset: contents undefined after power-up
	dmmap_ram #(.ADDR_W(8)) u_iram (
		.sys_clk_in (sys_clk_in),
		.wr_en_in   (iram_we),
		.addr_in    (eff_addr),
		.wdata_in   (iram_wdata),
		.rdata_out  (iram_rdata)
	);

	dmmap_ram #(.ADDR_W(8)) u_exp_ram (
		.sys_clk_in (sys_clk_in),
		.wr_en_in   (exp_sel && wr_in),
		.addr_in    (ext_addr[7:0]),
		.wdata_in   (wdata_in),
		.rdata_out  (exp_rdata)
	);

	// ----------------------------------------------------------------
	// SPECIAL_FUNCTION_REGISTER registers
	// ----------------------------------------------------------------
	logic sfr_wr;
	logic [7:0] sfr_a;
	assign sfr_wr = sfr_sel && wr_in;
	assign sfr_a  = eff_addr;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			program_status_word_reg <= `DMMAP_STATUS_RESET;
		else if (sfr_wr && sfr_a == `DMMAP_STATUS_ADDR)
			program_status_word_reg <= wdata_in;
	end

	// Increment toggles bit 0 alone and no other bit moves; bit 2 stays zero
	// on writes, and the flag above it never changes on an increment
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			aux_control_reg <= `DMMAP_AUX_RESET;
		else if (aux_inc_in)
		begin
			aux_control_reg[`DMMAP_AUX_SEL] <=
				~aux_control_reg[`DMMAP_AUX_SEL];
		end
		else if (sfr_wr && sfr_a == `DMMAP_SFR_AUX)
		begin
			aux_control_reg <= wdata_in;
			aux_control_reg[`DMMAP_AUX_ZERO] <= 1'b0;
		end
	end

	// Only the selected pointer moves; the other holds
	logic [15:0] ptr_next;
	logic        ptr_load;
	always_comb
	begin
		ptr_next = active_data_pointer;
		ptr_load = 1'b0;
		if (ptr_inc_in)
		begin
			ptr_next = active_data_pointer + 16'h0001;
			ptr_load = 1'b1;
		end
		else if (sfr_wr && sfr_a == `DMMAP_PTR_HI)
		begin
			ptr_next = {wdata_in, active_data_pointer[7:0]};
			ptr_load = 1'b1;
		end
		else if (sfr_wr && sfr_a == `DMMAP_PTR_LO)
		begin
			ptr_next = {active_data_pointer[15:8], wdata_in};
			ptr_load = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			first_data_pointer_reg <= `DMMAP_PTR_RESET;
		else if (ptr_load && !pointer_select)
			first_data_pointer_reg <= ptr_next;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			second_data_pointer_reg <= `DMMAP_PTR_RESET;
		else if (ptr_load && pointer_select)
			second_data_pointer_reg <= ptr_next;
	end

	// ----------------------------------------------------------------
	// Read return
	// ----------------------------------------------------------------
	logic [7:0] sfr_rdata;
	always_comb
	begin
		sfr_rdata = 8'h00;
		unique case (sfr_a)
			`DMMAP_PTR_HI:      sfr_rdata = active_data_pointer[15:8];
			`DMMAP_PTR_LO:      sfr_rdata = active_data_pointer[7:0];
			`DMMAP_STATUS_ADDR: sfr_rdata = program_status_word_reg;
			`DMMAP_SFR_AUX:     sfr_rdata = aux_control_reg;
			default:            sfr_rdata = 8'h00;
		endcase
	end

	logic sfr_known;
	assign sfr_known = sfr_a == `DMMAP_PTR_HI || sfr_a == `DMMAP_PTR_LO ||
		sfr_a == `DMMAP_STATUS_ADDR || sfr_a == `DMMAP_SFR_AUX;

	// Sources are read combinationally and the answer is registered, so
	// every output leaves a flip-flop one cycle after its request
	logic [7:0] rdata_next;
	logic       rbit_next;

	always_comb
	begin
		rdata_next = sfr_rdata;
		if (iram_sel)
			rdata_next = iram_rdata;
		else if (exp_sel)
			rdata_next = exp_rdata;
	end

	assign rbit_next = bit_sel ?
		iram_rdata[bit_addr_in[2:0]] : 1'b0;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			rdata_out    <= 8'h00;
			rbit_out     <= 1'b0;
			ack_out      <= 1'b0;
			sfr_miss_out <= 1'b0;
		end
		else
		begin
			rdata_out    <= rdata_next;
			rbit_out     <= rbit_next;
			ack_out      <= req_in;
			sfr_miss_out <= (sfr_sel && !sfr_known) ||
				(req_in && mode_in == DMMAP_MODE_EXT && ext_miss);
		end
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	// Select as it stands after this edge, so the pointer copy follows a
	// select change in the same cycle instead of one cycle late
	logic        sel_next;
	logic [15:0] adp_next;

	always_comb
	begin
		sel_next = pointer_select;
		if (aux_inc_in)
			sel_next = ~pointer_select;
		else if (sfr_wr && sfr_a == `DMMAP_SFR_AUX)
			sel_next = wdata_in[`DMMAP_AUX_SEL];
		adp_next = sel_next ? second_data_pointer_reg :
			first_data_pointer_reg;
		// A pointer being deselected is not the one to show
		if (ptr_load && sel_next == pointer_select)
			adp_next = ptr_next;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			active_data_pointer_out <= `DMMAP_PTR_RESET;
			pointer_select_out      <= 1'b0;
			bank_out                <= 2'b00;
		end
		else
		begin
			active_data_pointer_out <= adp_next;
			pointer_select_out      <= sel_next;
			bank_out <= (sfr_wr && sfr_a == `DMMAP_STATUS_ADDR) ?
				{wdata_in[`DMMAP_BANK_HI], wdata_in[`DMMAP_BANK_LO]} :
				{bank_select_high, bank_select_low};
		end
	end

endmodule : dmmap_top

// [tb/dmmap_top_props.sv]
// Port checks for the data memory map
`timescale 1ns/10ps
module dmmap_top_props
	import dmmap_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        req_in,
	input dmmap_mode_t      mode_in,
	input wire logic [15:0] addr_in,
	input wire logic        ptr_inc_in,
	input wire logic        aux_inc_in,
	input wire logic        ext_ptr_in,
	input wire logic        ack_out,
	input wire logic        sfr_miss_out,
	input wire logic [15:0] active_data_pointer_out,
	input wire logic        pointer_select_out,
	input wire logic [1:0]  bank_out
);
	logic [1:0] act_reg;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Work of the last two cycles may still be landing in the outputs
	always_ff @(posedge sys_clk_in)
		act_reg <= {act_reg[0], req_in | ptr_inc_in | aux_inc_in};
	a_ack_one_late: assert property (ack_out == $past(req_in))
		else $error("ack not one cycle after request");
	a_miss_with_ack: assert property (sfr_miss_out |-> ack_out)
		else $error("miss flagged without ack");
	a_ext_range: assert property (req_in && mode_in == DMMAP_MODE_EXT &&
		!ext_ptr_in |=> sfr_miss_out == ($past(addr_in) > 16'h00FF))
		else $error("external range decode wrong");
	a_aux_toggle: assert property (aux_inc_in && !req_in
		|-> ##[1:2] $changed(pointer_select_out))
		else $error("aux increment did not toggle select");
	a_sel_quiet: assert property (act_reg == 2'h0
		|-> $stable(pointer_select_out))
		else $error("select moved with no cause");
	a_bank_quiet: assert property (act_reg == 2'h0 |-> $stable(bank_out))
		else $error("bank moved with no cause");
	a_ptr_quiet: assert property (act_reg == 2'h0
		|-> $stable(active_data_pointer_out))
		else $error("pointer moved with no cause");
	a_reset_clear: assert property (disable iff (1'b0) rst_in ##1 rst_in
		|=> !ack_out && active_data_pointer_out == 16'h0000 &&
		!pointer_select_out && bank_out == 2'h0)
		else $error("outputs not cleared by reset");
	c_aux: cover property (aux_inc_in);
	c_miss: cover property (sfr_miss_out);
	c_ext: cover property (req_in && mode_in == DMMAP_MODE_EXT);
endmodule : dmmap_top_props

// [tb/dmmap_cpu_model.sv]
// Behavioural CPU core driving the data memory map
`timescale 1ns/10ps
module dmmap_cpu_model
	import dmmap_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        ack_in,
	input  wire logic [7:0]  rdata_in,
	input  wire logic        rbit_in,
	input  wire logic        miss_in,
	output logic             req_out,
	output logic             wr_out,
	output dmmap_mode_t      mode_out,
	output logic      [15:0] addr_out,
	output logic      [7:0]  wdata_out,
	output logic             reg_op_out,
	output logic      [2:0]  reg_num_out,
	output logic             bit_op_out,
	output logic      [6:0]  bit_addr_out,
	output logic             bit_wdata_out,
	output logic             ptr_inc_out,
	output logic             aux_inc_out,
	output logic             ext_ptr_out
);
	initial
	begin
		{req_out, wr_out, addr_out, wdata_out, reg_op_out, reg_num_out,
			bit_op_out, bit_addr_out, bit_wdata_out, ptr_inc_out,
			aux_inc_out, ext_ptr_out} = '0;
		mode_out = DMMAP_MODE_DIRECT;
	end
	// k packs register-operand, bit-operand and pointer-address flags;
	// a bit write takes its bit value from address bit 7
	task acc(input logic w, input dmmap_mode_t m, input logic [15:0] a,
		input logic [7:0] d, input logic [2:0] k, output logic [7:0] r,
		output logic b, output logic ms, output logic ok);
		@(negedge sys_clk_in);
		req_out = 1'b1;
		wr_out = w;
		mode_out = m;
		addr_out = a;
		wdata_out = d;
		{reg_op_out, bit_op_out, ext_ptr_out} = k;
		reg_num_out = a[2:0];
		bit_addr_out = a[6:0];
		bit_wdata_out = a[7];
		@(negedge sys_clk_in);
		ok = (ack_in === 1'b1);
		r = rdata_in;
		b = rbit_in;
		ms = miss_in;
		{req_out, reg_op_out, bit_op_out, ext_ptr_out} = 4'h0;
		// A released address or data bus never keeps showing its last value
		addr_out = ~a;
		wdata_out = ~d;
	endtask : acc
	task pulse(input logic p, input logic x);
		@(negedge sys_clk_in);
		ptr_inc_out = p;
		aux_inc_out = x;
		@(negedge sys_clk_in);
		ptr_inc_out = 1'b0;
		aux_inc_out = 1'b0;
		@(negedge sys_clk_in);
	endtask : pulse
endmodule : dmmap_cpu_model

// [tb/data_memory_map_dual_pointer_tb_top.sv]
// Self-checking bench for the data memory map
`timescale 1ns/10ps
module data_memory_map_dual_pointer_tb_top;
	import dmmap_pkg::*;
	localparam dmmap_mode_t DIR = DMMAP_MODE_DIRECT;
	localparam dmmap_mode_t IND = DMMAP_MODE_INDIRECT;
	localparam dmmap_mode_t EXT = DMMAP_MODE_EXT;
	logic        sys_clk_in, rst_in, req_in, wr_in, reg_op_in, bit_op_in;
	logic        bit_wdata_in, ptr_inc_in, aux_inc_in, ext_ptr_in;
	logic        rbit_out, ack_out, sfr_miss_out, pointer_select_out;
	dmmap_mode_t mode_in;
	logic [15:0] addr_in, active_data_pointer_out;
	logic [7:0]  wdata_in, rdata_out, r;
	logic [2:0]  reg_num_in;
	logic [6:0]  bit_addr_in;
	logic [1:0]  bank_out;
	logic        b, ms, ok;
	int          bad_count, tests_run;
	dmmap_top DUT (.*);
	dmmap_cpu_model cpu (.sys_clk_in(sys_clk_in), .ack_in(ack_out),
		.rdata_in(rdata_out), .rbit_in(rbit_out), .miss_in(sfr_miss_out),
		.req_out(req_in), .wr_out(wr_in), .mode_out(mode_in),
		.addr_out(addr_in), .wdata_out(wdata_in), .reg_op_out(reg_op_in),
		.reg_num_out(reg_num_in), .bit_op_out(bit_op_in),
		.bit_addr_out(bit_addr_in), .bit_wdata_out(bit_wdata_in),
		.ptr_inc_out(ptr_inc_in), .aux_inc_out(aux_inc_in),
		.ext_ptr_out(ext_ptr_in));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task go(input logic w, input dmmap_mode_t m, input logic [15:0] a,
		input logic [7:0] d, input logic [2:0] k);
		cpu.acc(w, m, a, d, k, r, b, ms, ok);
		chk({15'h0, ok}, 16'h0001);
	endtask : go
	task results;
		$display("Checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task t_segments;
		go(1'b1, IND, 16'h0090, 8'h3C, 3'h0);
		go(1'b1, DIR, 16'h0090, 8'hC3, 3'h0);
		chk(ms, 16'h0001);
		go(1'b1, DIR, 16'h007F, 8'hA5, 3'h0);
		go(1'b0, IND, 16'h0090, 8'h00, 3'h0);
		chk(r, 16'h003C);
		go(1'b0, IND, 16'h007F, 8'h00, 3'h0);
		chk(r, 16'h00A5);
		$display("segments done");
	endtask : t_segments
	task t_bits;
		go(1'b1, DIR, 16'h0025, 8'h00, 3'h0);
		// Bit 2Bh set into a clear byte 25h: only the merge can give 08h
		go(1'b1, DIR, 16'h00AB, 8'h00, 3'h2);
		go(1'b0, DIR, 16'h0025, 8'h00, 3'h0);
		chk(r, 16'h0008);
		go(1'b0, DIR, 16'h002B, 8'h00, 3'h2);
		chk(b, 16'h0001);
		go(1'b0, DIR, 16'h002A, 8'h00, 3'h2);
		chk(b, 16'h0000);
		$display("bits done");
	endtask : t_bits
	task t_pointers;
		go(1'b1, DIR, 16'h0083, 8'h12, 3'h0);
		go(1'b1, DIR, 16'h0084, 8'h34, 3'h0);
		// Sets select and the flag, and tries the stuck-at-zero bit
		go(1'b1, DIR, 16'h00A2, 8'h0D, 3'h0);
		chk(pointer_select_out, 16'h0001);
		chk(active_data_pointer_out, 16'h0000);
		go(1'b1, DIR, 16'h0083, 8'h00, 3'h0);
		go(1'b1, DIR, 16'h0084, 8'hFE, 3'h0);
		cpu.pulse(1'b1, 1'b0);
		chk(active_data_pointer_out, 16'h00FF);
		go(1'b1, EXT, 16'h0000, 8'h77, 3'h1);
		go(1'b0, EXT, 16'h00FF, 8'h00, 3'h0);
		chk(r, 16'h0077);
		go(1'b0, DIR, 16'h00A2, 8'h00, 3'h0);
		chk(r, 16'h0009);
		cpu.pulse(1'b0, 1'b1);
		chk(pointer_select_out, 16'h0000);
		chk(active_data_pointer_out, 16'h1234);
		go(1'b1, EXT, 16'h0100, 8'h55, 3'h0);
		chk(ms, 16'h0001);
		cpu.pulse(1'b0, 1'b1);
		chk(pointer_select_out, 16'h0001);
		go(1'b0, DIR, 16'h0084, 8'h00, 3'h0);
		chk(r, 16'h00FF);
		$display("pointers done");
	endtask : t_pointers
	task t_banks;
		for (int i = 0; i < 4; i++)
		begin
			go(1'b1, DIR, 16'h00D0, 8'(i << 3), 3'h0);
			go(1'b1, DIR, 16'h0007, 8'(8'h40 + i), 3'h4);
			chk(bank_out, 16'(i));
			go(1'b0, IND, 16'(i * 8 + 7), 8'h00, 3'h0);
			chk(r, 16'(8'h40 + i));
		end
		$display("banks done");
	endtask : t_banks
	task t_reset;
		@(negedge sys_clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		chk(active_data_pointer_out, 16'h0000);
		chk(pointer_select_out, 16'h0000);
		chk(bank_out, 16'h0000);
		$display("reset done");
	endtask : t_reset
	initial
	begin
		bad_count = 0;
		tests_run = 0;
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		t_segments;
		t_bits;
		t_pointers;
		t_banks;
		t_reset;
		results;
	end
	initial
	begin
		#100000;
		bad_count++;
		results;
	end
endmodule : data_memory_map_dual_pointer_tb_top
bind dmmap_top dmmap_top_props P (.*);
